// ### pief_pkg.sv
package pief_pkg;

    ////////////////////////////////////////////////////////////////////////
    // bus geometry
    localparam int unsigned ADDR_W = 10;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned REG_W = 8;
    localparam int unsigned IDX_W = 8;
    localparam int unsigned IDX_LSB = 2;
    localparam int unsigned FLAG_VEC_W = 16;

    ////////////////////////////////////////////////////////////////////////
    // register indices, byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_CORE_CONTROL = 8'h0B;
    localparam logic [IDX_W-1:0] IDX_FLAG_ONE = 8'h0C;
    localparam logic [IDX_W-1:0] IDX_FLAG_TWO = 8'h0D;
    localparam logic [IDX_W-1:0] IDX_ENABLE_ONE = 8'h8C;
    localparam logic [IDX_W-1:0] IDX_ENABLE_TWO = 8'h8D;

    ////////////////////////////////////////////////////////////////////////
    // bit positions, first enable and flag registers
    localparam int unsigned BIT_CONVERTER = 6;
    localparam int unsigned BIT_SERIAL_RX = 5;
    localparam int unsigned BIT_SERIAL_TX = 4;
    localparam int unsigned BIT_SYNC_PORT = 3;
    localparam int unsigned BIT_CAPCOMP = 2;
    localparam int unsigned BIT_TIMER_TWO = 1;
    localparam int unsigned BIT_TIMER_ONE = 0;
    // second enable and flag registers
    localparam int unsigned BIT_OSC_FAIL = 7;
    localparam int unsigned BIT_COMPARATOR = 6;
    localparam int unsigned BIT_EEPROM = 4;
    // core interrupt control
    localparam int unsigned BIT_GLOBAL = 7;
    localparam int unsigned BIT_GROUP = 6;

    ////////////////////////////////////////////////////////////////////////
    // implemented-bit masks and reset value
    localparam logic [REG_W-1:0] ENABLE_ONE_MASK = 8'h7F;
    localparam logic [REG_W-1:0] FLAG_ONE_WRITABLE = 8'h4F;
    localparam logic [REG_W-1:0] TWO_MASK = 8'hD0;
    localparam logic [REG_W-1:0] CORE_MASK = 8'hC0;
    localparam logic [REG_W-1:0] CONVERTER_MASK = 8'h40;
    localparam logic [REG_W-1:0] ALL_ONES = 8'hFF;
    localparam logic [REG_W-1:0] REG_RESET = 8'h00;
    localparam logic [DATA_W-1:0] READ_RESET = 32'h0000_0000;

    ////////////////////////////////////////////////////////////////////////
    // capture/compare unit mode codes
    localparam logic [1:0] CCP_CAPTURE = 2'h0;
    localparam logic [1:0] CCP_COMPARE = 2'h1;
    localparam logic [1:0] CCP_PWM = 2'h2;

endpackage : pief_pkg

// ### pief_flag_bit.sv
module pief_flag_bit
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // hardware side
    input wire logic eventSet,
    input wire logic hwClear,
    // software side
    input wire logic wrEn,
    input wire logic wrData,
    // state
    output logic flag
);

    logic next_flag;

    // event wins over any clear in the same cycle
    always_comb
    begin
        next_flag = flag;
        if (wrEn)
            next_flag = wrData;
        if (hwClear)
            next_flag = 1'b0;
        if (eventSet)
            next_flag = 1'b1;
    end

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            flag <= 1'b0;
        else
            flag <= next_flag;
    end

endmodule : pief_flag_bit

// ### pief_apb_slave.sv
module pief_apb_slave
    import pief_pkg::*;
(
    // apb request
    input wire logic psel,
    input wire logic penable,
    input wire logic [ADDR_W-1:0] paddr,
    // decoded
    output logic pready,
    output logic setupPhase,
    output logic commit,
    output logic mapped,
    output logic [IDX_W-1:0] regIndex
);

    // zero wait states: every access phase completes at once
    assign pready = 1'b1;
    assign setupPhase = psel && !penable;
    assign commit = psel && penable;
    assign regIndex = paddr[ADDR_W-1:IDX_LSB];

    always_comb
    begin
        mapped = 1'b0;
        if (paddr[IDX_LSB-1:0] == 2'h0)
        begin
            case (regIndex)
                IDX_CORE_CONTROL,
                IDX_FLAG_ONE,
                IDX_FLAG_TWO,
                IDX_ENABLE_ONE,
                IDX_ENABLE_TWO: mapped = 1'b1;
                default: mapped = 1'b0;
            endcase
        end
    end

endmodule : pief_apb_slave

// ### pief_irq_regs.sv
// What this block does
// - Event flags set on their event regardless of any enable bit.
// - First enable register at index 8C, bit 7 zero, bits 6..0 enables.
// - Converter enable and flag exist only on the converter variant.
// - First flag register at index 0C, bit 7 zero, same order.
// - Receive flag read-only, follows receive buffer full.
// - Transmit flag read-only, follows transmit buffer empty.
// - Sync port flag sets on completion, cleared while port waits unless completion comes in the same cycle.
// - Capcomp flag sets on capture or compare match, unused in pwm.
// - Timer two match flag sets on period match, held until cleared.
// - Timer one overflow flag sets on overflow, held until cleared.
// - Converter flag sets on conversion done, cleared while busy unless done comes in the same cycle.
// - Second enable register: bits 7, 6 and 4, others zero.
// - Interrupt only with flag, enable, group and global enables.
// - Second flag register at index 0D: bits 7, 6, 4, others zero.
//
// The APB slave port was chosen for this implementation.
module pief_irq_regs
    import pief_pkg::*;
#(
    parameter bit HAS_CONVERTER = 1'b1
)
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [DATA_W-1:0] pwdata,
    output logic [DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    // converter events
    input wire logic converterDone,
    input wire logic converterBusy,
    // serial unit buffer state
    input wire logic rxBufferFull,
    input wire logic txBufferEmpty,
    // sync serial port events
    input wire logic syncPortDone,
    input wire logic syncPortWaiting,
    // capture/compare unit
    input wire logic [1:0] capcompMode,
    input wire logic timerOneCapture,
    input wire logic timerOneCompareMatch,
    // timers
    input wire logic timerTwoMatch,
    input wire logic timerOneOverflow,
    // second group events
    input wire logic oscFail,
    input wire logic comparatorChange,
    input wire logic eepromWriteDone,
    // interrupt request to the core
    output logic irqRequest
);

    ////////////////////////////////////////////////////////////////////////
    // variant masks
    localparam logic [REG_W-1:0] VARIANT_MASK =
        HAS_CONVERTER ? ALL_ONES : ~CONVERTER_MASK;
    localparam logic [FLAG_VEC_W-1:0] WRITABLE =
        {TWO_MASK, FLAG_ONE_WRITABLE & VARIANT_MASK};

    logic setupPhase;
    logic commit;
    logic mapped;
    logic [IDX_W-1:0] regIndex;
    logic writeCommit;
    logic [REG_W-1:0] coreControl;
    logic [REG_W-1:0] enableOne;
    logic [REG_W-1:0] enableTwo;
    logic [REG_W-1:0] flagOne;
    logic [REG_W-1:0] flagTwo;
    logic rxFlag;
    logic txFlag;
    logic capcompEvent;
    logic [FLAG_VEC_W-1:0] eventVec;
    logic [FLAG_VEC_W-1:0] clearVec;
    logic [FLAG_VEC_W-1:0] wrVec;
    logic [FLAG_VEC_W-1:0] wrDataVec;
    logic [FLAG_VEC_W-1:0] flagBits;
    logic [REG_W-1:0] readByte;
    logic next_irq;

    ////////////////////////////////////////////////////////////////////////
    // bus decode
    pief_apb_slave u_apb
    (
        .psel(psel),
        .penable(penable),
        .paddr(paddr),
        .pready(pready),
        .setupPhase(setupPhase),
        .commit(commit),
        .mapped(mapped),
        .regIndex(regIndex)
    );

    assign writeCommit = commit && pwrite && mapped;

    ////////////////////////////////////////////////////////////////////////
    // control and enable registers
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            coreControl <= REG_RESET;
        else if (writeCommit && regIndex == IDX_CORE_CONTROL)
            coreControl <= pwdata[REG_W-1:0] & CORE_MASK;
    end

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            enableOne <= REG_RESET;
        else if (writeCommit && regIndex == IDX_ENABLE_ONE)
            enableOne <= pwdata[REG_W-1:0] & ENABLE_ONE_MASK
                & VARIANT_MASK;
    end

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            enableTwo <= REG_RESET;
        else if (writeCommit && regIndex == IDX_ENABLE_TWO)
            enableTwo <= pwdata[REG_W-1:0] & TWO_MASK;
    end

    ////////////////////////////////////////////////////////////////////////
    // read-only serial flags mirror the buffer state
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rxFlag <= 1'b0;
            txFlag <= 1'b0;
        end
        else
        begin
            rxFlag <= rxBufferFull;
            txFlag <= txBufferEmpty;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // sticky flags
    always_comb
    begin
        capcompEvent = 1'b0;
        case (capcompMode)
            CCP_CAPTURE: capcompEvent = timerOneCapture;
            CCP_COMPARE: capcompEvent = timerOneCompareMatch;
            default: capcompEvent = 1'b0;
        endcase
    end

    always_comb
    begin
        eventVec = '0;
        eventVec[BIT_CONVERTER] = converterDone;
        eventVec[BIT_SYNC_PORT] = syncPortDone;
        eventVec[BIT_CAPCOMP] = capcompEvent;
        eventVec[BIT_TIMER_TWO] = timerTwoMatch;
        eventVec[BIT_TIMER_ONE] = timerOneOverflow;
        eventVec[REG_W + BIT_OSC_FAIL] = oscFail;
        eventVec[REG_W + BIT_COMPARATOR] = comparatorChange;
        eventVec[REG_W + BIT_EEPROM] = eepromWriteDone;
        clearVec = '0;
        clearVec[BIT_CONVERTER] = converterBusy;
        clearVec[BIT_SYNC_PORT] = syncPortWaiting;
    end

    assign wrVec = {{REG_W{writeCommit && regIndex == IDX_FLAG_TWO}},
                    {REG_W{writeCommit && regIndex == IDX_FLAG_ONE}}};
    assign wrDataVec = {pwdata[REG_W-1:0], pwdata[REG_W-1:0]};

    for (genvar i = 0; i < FLAG_VEC_W; i++)
    begin : g_flag
        if (WRITABLE[i])
        begin : g_impl
            pief_flag_bit u_bit
            (
                .ref_clk(ref_clk),
                .resetn(resetn),
                .eventSet(eventVec[i]),
                .hwClear(clearVec[i]),
                .wrEn(wrVec[i]),
                .wrData(wrDataVec[i]),
                .flag(flagBits[i])
            );
        end
        else
        begin : g_none
            assign flagBits[i] = 1'b0;
        end
    end

    always_comb
    begin
        flagOne = flagBits[REG_W-1:0];
        flagOne[BIT_SERIAL_RX] = rxFlag;
        flagOne[BIT_SERIAL_TX] = txFlag;
        flagTwo = flagBits[FLAG_VEC_W-1:REG_W];
    end

    ////////////////////////////////////////////////////////////////////////
    // interrupt request
    assign next_irq = coreControl[BIT_GLOBAL] && coreControl[BIT_GROUP]
        && (|(flagOne & enableOne) || |(flagTwo & enableTwo));

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            irqRequest <= 1'b0;
        else
            irqRequest <= next_irq;
    end

    ////////////////////////////////////////////////////////////////////////
    // read data, captured in the setup cycle
    always_comb
    begin
        case (regIndex)
            IDX_CORE_CONTROL: readByte = coreControl;
            IDX_FLAG_ONE: readByte = flagOne;
            IDX_FLAG_TWO: readByte = flagTwo;
            IDX_ENABLE_ONE: readByte = enableOne;
            IDX_ENABLE_TWO: readByte = enableTwo;
            default: readByte = REG_RESET;
        endcase
    end

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            prdata <= READ_RESET;
            pslverr <= 1'b0;
        end
        else if (setupPhase)
        begin
            prdata <= {{(DATA_W-REG_W){1'b0}}, readByte};
            pslverr <= !mapped;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // assertions
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!resetn);

    a_event_sets_flag: assert property (
        timerOneOverflow |=> flagOne[BIT_TIMER_ONE] && flagBits[BIT_TIMER_ONE])
        else $error("overflow event did not set its flag");

    a_enable_one_read: assert property (
        commit && !pwrite && regIndex == IDX_ENABLE_ONE && mapped
        |-> prdata[REG_W-1] == 1'b0 && prdata[REG_W-2:0] ==
            $past(enableOne[REG_W-2:0]))
        else $error("enable one readback wrong");

    a_variant_zero: assert property (
        !HAS_CONVERTER
        |-> !enableOne[BIT_CONVERTER] && !flagOne[BIT_CONVERTER])
        else $error("converter bits present on variant without converter");

    a_flag_one_read: assert property (
        setupPhase && !pwrite && regIndex == IDX_FLAG_ONE && mapped
        |=> prdata[REG_W-1:0] == $past(flagOne) && !prdata[REG_W-1])
        else $error("flag one readback wrong");

    a_rx_readonly: assert property (
        writeCommit && regIndex == IDX_FLAG_ONE && !rxBufferFull
        |=> !flagOne[BIT_SERIAL_RX])
        else $error("receive flag was writable");

    a_tx_follows: assert property (
        txBufferEmpty ##1 txBufferEmpty |-> flagOne[BIT_SERIAL_TX])
        else $error("transmit flag does not follow buffer");

    a_sync_waiting: assert property (
        syncPortWaiting && !syncPortDone |=> !flagOne[BIT_SYNC_PORT])
        else $error("sync flag set while port waiting");

    a_capcomp_pwm: assert property (
        capcompMode == CCP_PWM && !flagOne[BIT_CAPCOMP] && !writeCommit
        |=> !flagOne[BIT_CAPCOMP])
        else $error("capcomp flag set in pwm mode");

    a_timer_two_hold: assert property (
        flagOne[BIT_TIMER_TWO] && !writeCommit |=> flagOne[BIT_TIMER_TWO])
        else $error("timer two flag cleared without software");

    a_timer_one_hold: assert property (
        flagOne[BIT_TIMER_ONE] && !writeCommit [*2] |=> flagOne[BIT_TIMER_ONE])
        else $error("timer one flag cleared without software");

    a_converter_busy: assert property (
        converterBusy && !converterDone |=> !flagOne[BIT_CONVERTER])
        else $error("converter flag set while busy");

    a_enable_two_bits: assert property (
        commit && !pwrite && regIndex == IDX_ENABLE_TWO && mapped
        |-> (prdata[REG_W-1:0] & ~TWO_MASK) == REG_RESET)
        else $error("unimplemented enable two bit read nonzero");

    a_irq_gate: assert property (
        irqRequest |-> $past(coreControl[BIT_GLOBAL] && coreControl[BIT_GROUP])
            && $past((flagOne & enableOne) != REG_RESET
            || (flagTwo & enableTwo) != REG_RESET))
        else $error("interrupt raised without all enables");

    a_irq_raise: assert property (
        coreControl[BIT_GLOBAL] && coreControl[BIT_GROUP]
        && (flagOne & enableOne) != REG_RESET |=> irqRequest)
        else $error("interrupt missing with all enables set");

    a_flag_two_bits: assert property (
        ((flagTwo & ~TWO_MASK) == REG_RESET)
        and (oscFail |=> flagTwo[BIT_OSC_FAIL]))
        else $error("flag two layout wrong");

    a_reset_clear: assert property (disable iff (1'b0)
        $rose(resetn) |-> enableOne == REG_RESET && enableTwo == REG_RESET
            && flagBits == '0 && coreControl == REG_RESET)
        else $error("registers not clear after reset");

    a_write_sets: assert property (
        writeCommit && regIndex == IDX_FLAG_ONE && pwdata[BIT_TIMER_TWO]
        |=> flagOne[BIT_TIMER_TWO])
        else $error("write of one did not set flag");

    c_irq_raised: cover property (!irqRequest ##1 irqRequest);
    c_flag_cleared: cover property (
        flagOne[BIT_CAPCOMP] ##1 !flagOne[BIT_CAPCOMP]);
    c_unmapped: cover property (commit && pslverr);
    c_group_two_irq: cover property (irqRequest && enableTwo != REG_RESET);
    c_set_wins: cover property (
        writeCommit && regIndex == IDX_FLAG_TWO && eepromWriteDone);

endmodule : pief_irq_regs

// ### pief_periph_model.sv
module pief_periph_model
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // requests from the bench, one bit per event source
    input wire logic [8:0] fireReq,
    // event pulses into the block
    output logic converterDone,
    output logic syncPortDone,
    output logic timerOneCapture,
    output logic timerOneCompareMatch,
    output logic timerTwoMatch,
    output logic timerOneOverflow,
    output logic oscFail,
    output logic comparatorChange,
    output logic eepromWriteDone
);
    logic [8:0] lastReq;
    logic [8:0] pulse;

    ////////////////////////////////////////////////////////////////////////
    // one-cycle event per request edge, however long it is held
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            lastReq <= '0;
            pulse <= '0;
        end
        else
        begin
            lastReq <= fireReq;
            pulse <= fireReq & ~lastReq;
        end
    end

    assign {eepromWriteDone, comparatorChange, oscFail, timerOneOverflow,
            timerTwoMatch, timerOneCompareMatch, timerOneCapture,
            syncPortDone, converterDone} = pulse;
endmodule : pief_periph_model

// ### tb_top.sv
module tb_top import pief_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [ADDR_W-1:0] ADDR_F1 = {IDX_FLAG_ONE, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_F2 = {IDX_FLAG_TWO, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_E1 = {IDX_ENABLE_ONE, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_E2 = {IDX_ENABLE_TWO, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_CORE = {IDX_CORE_CONTROL, 2'b00};
    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [DATA_W-1:0] pwdata = '0;
    logic [DATA_W-1:0] prdata;
    logic pready, pslverr, irqRequest;
    logic converterBusy = 1'b0;
    logic rxBufferFull = 1'b0;
    logic txBufferEmpty = 1'b0;
    logic syncPortWaiting = 1'b0;
    logic [1:0] capcompMode = 2'h0;
    logic [8:0] fireReq = '0;
    logic converterDone, syncPortDone, timerOneCapture, timerOneCompareMatch;
    logic timerTwoMatch, timerOneOverflow, oscFail, comparatorChange;
    logic eepromWriteDone;
    logic [DATA_W-1:0] prdataLite;
    logic [DATA_W-1:0] rdvLite;
    logic irqLite;
    logic [DATA_W-1:0] rdv;
    logic errv;
    int num_errors = 0;
    int num_checks = 0;
    int cycles = 0;
    int seed = 19;
    int f1 = 0, f2 = 0, e1 = 0, e2 = 0, cc = 0;
    int evBit [9] = '{6, 3, 2, 2, 1, 0, 7, 6, 4};

    always #25 ref_clk = ~ref_clk;

    pief_periph_model peer (.ref_clk(ref_clk), .resetn(resetn),
        .fireReq(fireReq), .converterDone(converterDone),
        .syncPortDone(syncPortDone), .timerOneCapture(timerOneCapture),
        .timerOneCompareMatch(timerOneCompareMatch),
        .timerTwoMatch(timerTwoMatch), .timerOneOverflow(timerOneOverflow),
        .oscFail(oscFail), .comparatorChange(comparatorChange),
        .eepromWriteDone(eepromWriteDone));

    pief_irq_regs #(.HAS_CONVERTER(1'b1)) dut (.ref_clk(ref_clk),
        .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .converterDone(converterDone),
        .converterBusy(converterBusy), .rxBufferFull(rxBufferFull),
        .txBufferEmpty(txBufferEmpty), .syncPortDone(syncPortDone),
        .syncPortWaiting(syncPortWaiting), .capcompMode(capcompMode),
        .timerOneCapture(timerOneCapture),
        .timerOneCompareMatch(timerOneCompareMatch),
        .timerTwoMatch(timerTwoMatch), .timerOneOverflow(timerOneOverflow),
        .oscFail(oscFail), .comparatorChange(comparatorChange),
        .eepromWriteDone(eepromWriteDone), .irqRequest(irqRequest));

    // variant without the converter, same stimulus
    pief_irq_regs #(.HAS_CONVERTER(1'b0)) dut_lite (.ref_clk(ref_clk),
        .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdataLite), .pready(),
        .pslverr(), .converterDone(converterDone),
        .converterBusy(converterBusy), .rxBufferFull(rxBufferFull),
        .txBufferEmpty(txBufferEmpty), .syncPortDone(syncPortDone),
        .syncPortWaiting(syncPortWaiting), .capcompMode(capcompMode),
        .timerOneCapture(timerOneCapture),
        .timerOneCompareMatch(timerOneCompareMatch),
        .timerTwoMatch(timerTwoMatch), .timerOneOverflow(timerOneOverflow),
        .oscFail(oscFail), .comparatorChange(comparatorChange),
        .eepromWriteDone(eepromWriteDone), .irqRequest(irqLite));

    ////////////////////////////////////////////////////////////////////////
    task automatic end_of_test();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : end_of_test

    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            num_errors++;
            $display("[FAIL] %0t run hung", $time);
            end_of_test();
        end
    end

    task automatic chk(input logic [DATA_W-1:0] got, input int exp);
        num_checks++;
        if (got !== DATA_W'(exp))
        begin
            num_errors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic apb(input logic wr, input logic [ADDR_W-1:0] a,
                       input logic [DATA_W-1:0] d);
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        @(posedge ref_clk);
        while (pready !== 1'b1)
            @(posedge ref_clk);
        rdv = prdata;
        errv = pslverr;
        rdvLite = prdataLite;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rd(input logic [ADDR_W-1:0] a, input int exp);
        int expLite;
        expLite = (a == ADDR_F1 || a == ADDR_E1) ? exp & 8'hBF : exp;
        apb(1'b0, a, '0);
        chk(rdv, exp);
        chk(32'(errv), 0);
        chk(rdvLite, expLite);
    endtask : rd

    // model keeps only the writable bits of each register
    task automatic wr(input logic [ADDR_W-1:0] a, input int d);
        apb(1'b1, a, DATA_W'(d & 8'hFF));
        case (a)
            ADDR_F1: f1 = (f1 & 8'h30) | (d & 8'h4F);
            ADDR_F2: f2 = d & 8'hD0;
            ADDR_E1: e1 = d & 8'h7F;
            ADDR_E2: e2 = d & 8'hD0;
            default: cc = d & 8'hC0;
        endcase
    endtask : wr

    task automatic fire(input int i, input bit upd);
        @(posedge ref_clk);
        fireReq[i] <= 1'b1;
        @(posedge ref_clk);
        fireReq[i] <= 1'b0;
        repeat (3) @(posedge ref_clk);
        if (upd && i < 6)
            f1 |= 1 << evBit[i];
        else if (upd)
            f2 |= 1 << evBit[i];
    endtask : fire

    task automatic irqchk();
        int exp;
        repeat (3) @(posedge ref_clk);
        exp = (cc >> 7) & (cc >> 6) & 1 & int'(((f1 & e1) | (f2 & e2)) != 0);
        chk(32'(irqRequest), exp);
        chk(32'(irqLite), exp);
    endtask : irqchk

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        int i;
        repeat (4) @(posedge ref_clk);
        resetn <= 1'b1;
        rd(ADDR_F1, 0);
        rd(ADDR_F2, 0);
        rd(ADDR_E1, 0);
        rd(ADDR_E2, 0);
        rd(ADDR_CORE, 0);
        apb(1'b0, 10'h000, '0);
        chk(32'(errv), 1);
        apb(1'b1, 10'h231, 32'h0000_00FF);
        chk(32'(errv), 1);
        rd(ADDR_E1, 0);
        $display("test reset done");
        for (i = 0; i < 4; i++)
        begin
            wr(ADDR_E1, $random(seed));
            rd(ADDR_E1, e1);
            wr(ADDR_E2, $random(seed));
            rd(ADDR_E2, e2);
            wr(ADDR_CORE, $random(seed));
            rd(ADDR_CORE, cc);
        end
        wr(ADDR_E1, 0);
        wr(ADDR_E2, 0);
        wr(ADDR_CORE, 0);
        $display("test enables done");
        for (i = 0; i < 9; i++)
        begin
            capcompMode <= (i == 3) ? CCP_COMPARE : CCP_CAPTURE;
            fire(i, 1'b1);
            rd((i < 6) ? ADDR_F1 : ADDR_F2, (i < 6) ? f1 : f2);
            wr((i < 6) ? ADDR_F1 : ADDR_F2, 0);
        end
        capcompMode <= CCP_PWM;
        fire(2, 1'b0);
        fire(3, 1'b0);
        rd(ADDR_F1, f1);
        $display("test events done");
        wr(ADDR_F1, 8'h48);
        rd(ADDR_F1, f1);
        converterBusy <= 1'b1;
        f1 &= ~8'h40;
        rd(ADDR_F1, f1);
        syncPortWaiting <= 1'b1;
        f1 &= ~8'h08;
        rd(ADDR_F1, f1);
        wr(ADDR_F1, 8'h48);
        f1 &= ~8'h48;
        rd(ADDR_F1, f1);
        converterBusy <= 1'b0;
        syncPortWaiting <= 1'b0;
        rxBufferFull <= 1'b1;
        txBufferEmpty <= 1'b1;
        f1 |= 8'h30;
        rd(ADDR_F1, f1);
        wr(ADDR_F1, 0);
        rd(ADDR_F1, f1);
        rxBufferFull <= 1'b0;
        f1 &= ~8'h20;
        rd(ADDR_F1, f1);
        txBufferEmpty <= 1'b0;
        f1 = 0;
        rd(ADDR_F1, f1);
        $display("test holds done");
        wr(ADDR_F2, 8'hFF);
        rd(ADDR_F2, f2);
        wr(ADDR_F2, 0);
        rd(ADDR_F2, f2);
        wr(ADDR_F1, 8'hFF);
        rd(ADDR_F1, f1);
        wr(ADDR_F1, 0);
        rd(ADDR_F1, f1);
        $display("test writes done");
        wr(ADDR_E1, 8'h01);
        wr(ADDR_F1, 8'h01);
        irqchk();
        wr(ADDR_CORE, 8'h80);
        irqchk();
        wr(ADDR_CORE, 8'hC0);
        irqchk();
        wr(ADDR_E1, 0);
        irqchk();
        wr(ADDR_F1, 0);
        wr(ADDR_E2, 8'h10);
        fire(8, 1'b1);
        irqchk();
        wr(ADDR_F2, 0);
        irqchk();
        $display("test interrupt done");
        end_of_test();
    end
endmodule : tb_top
